/* File: hw/link_addr.sv */
// Master-side addressing, liveness and data slot ordering for a serial field link.
// Assumes reset is the power-up event and all inputs are synchronous to clk_i.
// What this block does
// - Switch 0 auto, 1..E address, F none.
// - At most fourteen slaves per link.
// - Internal slave counts; thirteen external remain.
// - Master has no address; addresses unique.
// - Switch sampled only at power-up.
// - Manual order by switch address only.
// - Automatic: all switches zero, types unique.
// - Automatic output and input slot order fixed.
// - Automatic diagnosis starts with coupler self entry.
// - Absent types shift later types up.
// - Combination module data slot only when configured.
// - Bad addressing lights red link indicator.
// - Same baud rate everywhere.
// - Process image 128 inputs, 128 outputs.
// - Driver coils watched for open, short.
// - Lost participant flagged, others keep running.
// - Indicator off once all present again.
`timescale 1ns/1ns
`include "link_addr_params.svh"

module link_addr #(
   parameter int DATA_W = 16,
   parameter int COILS = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] switch_i,
   input wire logic int_slave_i,
   input wire logic baud_low_i,
   input wire logic [13:0] ext_addr_seen_i,
   input wire logic [4:0] type_present_i,
   input wire logic combi_out_cfg_i,
   input wire logic combi_in_cfg_i,
   input wire logic [13:0] alive_i,
   input wire logic [COILS-1:0] coil_open_i,
   input wire logic [COILS-1:0] coil_short_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [3:0] in_src_i,
   input wire logic [1:0] in_kind_i,
   input wire logic [DATA_W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [3:0] out_slot_o,
   output logic [1:0] out_kind_o,
   output logic [6:0] out_offset_o,
   output logic [DATA_W-1:0] out_data_o,
   output logic link_auto_o,
   output logic baud_low_o,
   output logic own_led_o,
   output logic addr_err_o,
   output logic [13:0] lost_o,
   output logic link_led_o,
   output logic fault_pulse_o,
   output logic image_ovf_o,
   output logic [COILS-1:0] coil_fault_o
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (DATA_W < 1 || DATA_W > `IMAGE_BITS || (`IMAGE_BITS % DATA_W) != 0)
   begin : g_bad_width
      $error("DATA_W must divide the process image width");
   end
   if (COILS < 1)
   begin : g_bad_coils
      $error("COILS must be at least one");
   end

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Position of a type among the present members of an area, from one.
   function automatic logic [3:0] rank(input logic [4:0] mask, input logic [2:0] idx);
      logic [3:0] n;
      n = 4'h1;
      for (int k = 0; k < 5; k++)
      begin
         if (k < int'(idx) && mask[k])
         begin
            n = n + 4'h1;
         end
      end
      return n;
   endfunction

   function automatic logic [13:0] addr_bit(input logic [3:0] a);
      return (a == `SW_AUTO || a == `SW_NOFUNC) ? 14'h0000 : 14'(14'h0001 << (a - 4'h1));
   endfunction

   // ------------------------------------------------------------
   // Power-up capture
   // ------------------------------------------------------------
   link_addr_pkg::phase_e phase_r;
   logic [3:0] sw_r;
   logic slave_r;

   // Switch, strap and baud rate are taken once after reset; later moves are ignored.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         phase_r <= link_addr_pkg::PH_CAPTURE;
         sw_r <= `SW_RESET;
         slave_r <= 1'b0;
         baud_low_o <= 1'b0;
      end
      else
      begin
         case (phase_r)
            link_addr_pkg::PH_CAPTURE:
            begin
               sw_r <= switch_i;
               slave_r <= int_slave_i;
               baud_low_o <= baud_low_i;
               phase_r <= link_addr_pkg::PH_RUN;
            end
            link_addr_pkg::PH_RUN:
            begin
               phase_r <= link_addr_pkg::PH_RUN;
            end
            default:
            begin
               phase_r <= link_addr_pkg::PH_CAPTURE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Address checking
   // ------------------------------------------------------------
   wire run_w = (phase_r == link_addr_pkg::PH_RUN);
   // The master itself holds no address; only the internal slave adds one.
   wire [13:0] own_bit_w = slave_r ? addr_bit(sw_r) : 14'h0000;
   wire [13:0] seen_w = ext_addr_seen_i | own_bit_w;
   wire own_dup_w = |(ext_addr_seen_i & own_bit_w);
   wire auto_w = slave_r ? (sw_r == `SW_AUTO) : (ext_addr_seen_i == 14'h0000);
   wire mixed_w = auto_w ? (|ext_addr_seen_i) : (slave_r && sw_r == `SW_AUTO);
   wire own_bad_w = slave_r && (sw_r == `SW_NOFUNC || (auto_w && sw_r != `SW_AUTO));
   // Contiguous from one means the set is 2^n-1.
   wire [14:0] seen_inc_w = {1'b0, seen_w} + 15'h0001;
   wire gap_w = !auto_w && ((seen_w == 14'h0000) || |({1'b0, seen_w} & seen_inc_w));
   wire addr_bad_w = own_bad_w || gap_w || mixed_w || own_dup_w;

   // ------------------------------------------------------------
   // Liveness
   // ------------------------------------------------------------
   logic [13:0] expect_r;
   wire [13:0] expect_nxt = expect_r | (alive_i & seen_w);
   // An address that has answered once and then falls silent is flagged lost; see lost_o.
   wire [13:0] lost_nxt = run_w ? (expect_nxt & ~alive_i) : 14'h0000;
   wire new_loss_w = |(lost_nxt & ~lost_o);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         expect_r <= 14'h0000;
         lost_o <= 14'h0000;
         fault_pulse_o <= 1'b0;
         link_led_o <= 1'b0;
         addr_err_o <= 1'b0;
         own_led_o <= 1'b0;
         link_auto_o <= 1'b0;
         coil_fault_o <= '0;
      end
      else
      begin
         expect_r <= run_w ? expect_nxt : 14'h0000;
         lost_o <= lost_nxt;
         fault_pulse_o <= new_loss_w;
         link_led_o <= run_w && (|lost_nxt || addr_bad_w);
         addr_err_o <= run_w && addr_bad_w;
         own_led_o <= run_w && own_bad_w;
         link_auto_o <= run_w && auto_w;
         coil_fault_o <= coil_open_i | coil_short_i;
      end
   end

   // ------------------------------------------------------------
   // Slot mapping
   // ------------------------------------------------------------
   // Combination module joins a data area only when it has data there.
   wire [4:0] out_mask_w = type_present_i & {combi_out_cfg_i, `OUT_AREA_TYPES};
   wire [4:0] in_mask_w = type_present_i & {combi_in_cfg_i, `IN_AREA_TYPES};
   wire [2:0] typ_w = in_src_i[2:0];
   wire typ_ok_w = (in_src_i < 4'h5);
   logic [3:0] slot_w;
   always_comb
   begin
      slot_w = `NO_SLOT;
      if (!auto_w)
      begin
         slot_w = (seen_w & addr_bit(in_src_i)) != 14'h0000 ? in_src_i : `NO_SLOT;
      end
      else if (in_kind_i == link_addr_pkg::KIND_DIAG)
      begin
         if (in_src_i == `SELF_DIAG_SLOT)
         begin
            slot_w = `SELF_DIAG_SLOT;
         end
         else if (in_src_i <= 4'h5 && type_present_i[3'(in_src_i - 4'h1)])
         begin
            slot_w = rank(type_present_i, 3'(in_src_i - 4'h1));
         end
      end
      else if (typ_ok_w && in_kind_i == link_addr_pkg::KIND_OUT && out_mask_w[typ_w])
      begin
         slot_w = rank(out_mask_w, typ_w);
      end
      else if (typ_ok_w && in_kind_i == link_addr_pkg::KIND_IN && in_mask_w[typ_w])
      begin
         slot_w = rank(in_mask_w, typ_w);
      end
   end

   wire is_diag_w = (in_kind_i == link_addr_pkg::KIND_DIAG);
   wire [10:0] offs_w = 11'((slot_w - 4'h1) * DATA_W);
   wire over_w = !is_diag_w && (11'(offs_w + DATA_W) > 11'(`IMAGE_BITS));
   wire self_w = is_diag_w && auto_w && (in_src_i == `SELF_DIAG_SLOT);
   wire keep_w = run_w && in_kind_i != 2'h3 && (slot_w != `NO_SLOT || self_w) && !over_w;

   // ------------------------------------------------------------
   // Two-entry buffer: output stage plus skid stage
   // ------------------------------------------------------------
   logic skid_v_r;
   logic [3:0] skid_slot_r;
   logic [1:0] skid_kind_r;
   logic [6:0] skid_offs_r;
   logic [DATA_W-1:0] skid_data_r;
   wire take_w = in_valid_i && in_ready_o;
   wire push_w = take_w && keep_w;
   wire load_w = !out_valid_o || out_ready_i;
   wire skid_nxt = (skid_v_r && !load_w) || (!skid_v_r && !load_w && push_w);
   wire [6:0] offs7_w = is_diag_w ? 7'h00 : offs_w[6:0];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         out_valid_o <= 1'b0;
         skid_v_r <= 1'b0;
         in_ready_o <= 1'b1;
         image_ovf_o <= 1'b0;
      end
      else
      begin
         if (load_w)
         begin
            out_valid_o <= skid_v_r || push_w;
         end
         skid_v_r <= skid_nxt;
         in_ready_o <= !skid_nxt;
         image_ovf_o <= image_ovf_o || (take_w && run_w && over_w);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (load_w)
      begin
         out_slot_o <= skid_v_r ? skid_slot_r : slot_w;
         out_kind_o <= skid_v_r ? skid_kind_r : in_kind_i;
         out_offset_o <= skid_v_r ? skid_offs_r : offs7_w;
         out_data_o <= skid_v_r ? skid_data_r : in_data_i;
      end
      if (!skid_v_r && !load_w && push_w)
      begin
         skid_slot_r <= slot_w;
         skid_kind_r <= in_kind_i;
         skid_offs_r <= offs7_w;
         skid_data_r <= in_data_i;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_stall;
      out_valid_o && !out_ready_i;
   endsequence

   sequence s_hold;
      out_valid_o && $stable(out_data_o) && $stable(out_slot_o);
   endsequence

   a_out_hold_stall: assert property (@(posedge clk_i) disable iff (rst_i)
      s_stall |=> s_hold)
      else $error("Output word changed while stalled");

   a_ready_skid: assert property (@(posedge clk_i) disable iff (rst_i)
      in_ready_o == !skid_v_r)
      else $error("Ready disagrees with skid occupancy");

   a_switch_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
      run_w && $past(run_w) |-> $stable(sw_r))
      else $error("Latched switch changed during operation");

   a_own_led_cause: assert property (@(posedge clk_i) disable iff (rst_i)
      run_w && own_bad_w |=> own_led_o)
      else $error("Bad own address did not light indicator");

   a_lost_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      run_w && expect_r[0] && !alive_i[0] |=> lost_o[0] && link_led_o)
      else $error("Lost participant not flagged");

   a_led_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      run_w && !addr_bad_w && (alive_i & expect_nxt) == expect_nxt |=> !link_led_o)
      else $error("Indicator stayed on with all present");

   a_gap_error: assert property (@(posedge clk_i) disable iff (rst_i)
      run_w && !auto_w && !seen_w[0] |=> addr_err_o)
      else $error("Missing address one not reported");

   a_manual_slot: assert property (@(posedge clk_i) disable iff (rst_i)
      !out_valid_o && push_w && !auto_w |=> out_slot_o == $past(in_src_i))
      else $error("Manual slot differs from switch address");

   a_self_diag: assert property (@(posedge clk_i) disable iff (rst_i)
      !out_valid_o && push_w && auto_w && is_diag_w && in_src_i == 4'h0
      |=> out_slot_o == 4'h0 ##0 out_offset_o == 7'h00)
      else $error("Coupler self entry not first diagnosis slot");

   a_no_loss_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      fault_pulse_o |-> (lost_o != 14'h0000) ##1 !fault_pulse_o || (lost_o != $past(lost_o)))
      else $error("Fault pulse without a new loss");

endmodule

/* File: inc/link_addr_params.svh */
// Named constants for the link addressing and slot allocation block.
// Assumes inclusion by bare name from design files under hw/.
`ifndef LINK_ADDR_PARAMS_SVH
`define LINK_ADDR_PARAMS_SVH

// ------------------------------------------------------------
// Address switch
// ------------------------------------------------------------
`define SW_AUTO 4'h0
`define SW_NOFUNC 4'hF
`define SW_RESET 4'h0

// ------------------------------------------------------------
// Link limits and process image
// ------------------------------------------------------------
`define MAX_NODES 14
`define MAX_EXT_WITH_SLAVE 13
`define IMAGE_BITS 128
`define SELF_DIAG_SLOT 4'h0
`define NO_SLOT 4'h0
// Module types that own a slot in the output and in the input area, combination aside.
`define OUT_AREA_TYPES 4'hB
`define IN_AREA_TYPES 4'h5

`endif

/* File: inc/link_addr_pkg.sv */
// Types shared by the link addressing block and its bench.
// Assumes no other package.
package link_addr_pkg;

   // Kind of a participant data word.
   typedef enum logic [1:0]
   {
      KIND_OUT = 2'h0,
      KIND_IN = 2'h1,
      KIND_DIAG = 2'h2
   } kind_e;

   // Module types, in diagnosis order; bit index into a presence mask.
   typedef enum logic [2:0]
   {
      NODE_PRESSURE_VALVE = 3'h0,
      NODE_VALVE_DRIVER = 3'h1,
      NODE_INPUT = 3'h2,
      NODE_OUTPUT = 3'h3,
      NODE_COMBI = 3'h4
   } node_e;

   typedef enum logic [1:0]
   {
      PH_CAPTURE = 2'b01,
      PH_RUN = 2'b10
   } phase_e;

endpackage

/* File: test/link_nodes.sv */
// Stand-in for the external participants on the link.
// Assumes the bench drives count_i and gone_i at the falling edge.
`timescale 1ns/1ns

module link_nodes (
   input wire logic clk_i,
   input wire logic [3:0] count_i,
   input wire logic [3:0] gone_i,
   output logic [13:0] seen_o,
   output logic [13:0] alive_o
);
   logic [13:0] set_w;
   logic [13:0] gone_w;

   // Manual addresses are 1..count with no gaps, one per participant.
   // A count of zero is a link where every switch sits at zero.
   assign set_w = 14'((15'h0001 << count_i) - 15'h0001);
   // A silenced participant stays known but stops answering.
   assign gone_w = 14'((15'h0001 << gone_i) >> 1);

   always_ff @(posedge clk_i)
   begin
      seen_o <= set_w;
      alive_o <= set_w & ~gone_w;
   end
endmodule

/* File: test/test_link_addr.sv */
// Self-checking bench for the link addressing block with a queue model.
// Assumes the design and the participant model are compiled first.
`timescale 1ns/1ns

module test_link_addr;
   localparam int DW = 16;
   logic clk_i = 0, rst_i = 1, int_slave_i = 0, baud_low_i = 0, in_valid_i = 0;
   logic combi_out_cfg_i = 0, combi_in_cfg_i = 0, out_ready_i = 0, hold = 0;
   logic [3:0] switch_i = 0, in_src_i = 0, cnt = 0, gone = 0, out_slot_o;
   logic [4:0] type_present_i = 0;
   logic [7:0] coil_open_i = 0, coil_short_i = 0, coil_fault_o;
   logic [1:0] in_kind_i = 0, out_kind_o;
   logic [15:0] in_data_i = 0, out_data_o, lfsr = 16'hB25C;
   logic [13:0] seen, alive, lost_o, seen_m;
   logic [6:0] out_offset_o;
   logic in_ready_o, out_valid_o, link_auto_o, baud_low_o, own_led_o, addr_err_o;
   logic link_led_o, fault_pulse_o, image_ovf_o, auto_m, ovf_m;
   logic [28:0] exp_q[$];
   int error_cnt = 0, n_compared = 0, cyc = 0, pulses = 0, p0;
   // Columns: internal slave, own switch, external count, auto (2 = open), error.
   int tbl[7][5] = '{'{0, 0, 10, 0, 0}, '{1, 0, 0, 1, 0}, '{1, 15, 0, 2, 1},
      '{1, 3, 2, 0, 0}, '{1, 2, 2, 0, 1}, '{1, 5, 3, 0, 1}, '{0, 0, 0, 1, 0}};

   link_addr #(.DATA_W(DW), .COILS(8)) link_addr_i (.clk_i, .rst_i, .switch_i,
      .int_slave_i, .baud_low_i, .ext_addr_seen_i(seen), .type_present_i,
      .combi_out_cfg_i, .combi_in_cfg_i, .alive_i(alive), .coil_open_i, .coil_short_i,
      .in_valid_i, .in_ready_o, .in_src_i, .in_kind_i, .in_data_i, .out_valid_o,
      .out_ready_i, .out_slot_o, .out_kind_o, .out_offset_o, .out_data_o, .link_auto_o,
      .baud_low_o, .own_led_o, .addr_err_o, .lost_o, .link_led_o, .fault_pulse_o,
      .image_ovf_o, .coil_fault_o);
   link_nodes link_nodes_i (.clk_i, .count_i(cnt), .gone_i(gone), .seen_o(seen),
      .alive_o(alive));

   initial
      forever #10 clk_i = ~clk_i;

   // ----
   // Model and checking
   // ----
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction

   // Slot a word should land in; -1 when it must be dropped.
   function automatic int slot_of(int s, int k);
      int r;
      logic [4:0] m;
      r = 1;
      m = (k == 0) ? {combi_out_cfg_i, 4'hB} : {combi_in_cfg_i, 4'h5};
      m = m & type_present_i;
      if (k == 3)
         return -1;
      if (!auto_m)
      begin
         if (s == 0 || s > 14 || !seen_m[s-1])
            return -1;
         r = s;
      end
      else if (k == 2)
      begin
         if (s > 5 || (s > 0 && !type_present_i[s-1]))
            return -1;
         r = (s > 0);
         for (int t = 0; t < s - 1; t++)
            r += type_present_i[t];
      end
      else
      begin
         if (s > 4 || !m[s])
            return -1;
         for (int t = 0; t < s; t++)
            r += m[t];
      end
      if (k < 2 && r * DW > 128)
      begin
         ovf_m = 1;
         return -1;
      end
      return r;
   endfunction

   task chk(string what, logic [28:0] e, logic [28:0] g);
      n_compared++;
      if (e !== g)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask

   task conclude();
      if (error_cnt == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (fault_pulse_o === 1'b1)
         pulses <= pulses + 1;
      if (!rst_i && out_valid_o === 1'b1 && out_ready_i === 1'b1)
         chk("word", (exp_q.size() > 0) ? exp_q.pop_front() : 'x,
            {out_slot_o, out_kind_o, out_offset_o, out_data_o});
   end

   // The far side stalls one cycle in three, or fully while hold is set.
   always @(negedge clk_i)
      out_ready_i <= !hold && (cyc % 3 != 2);

   always @(posedge clk_i)
      if (cyc == 9000)
      begin
         error_cnt++;
         conclude();
      end

   // ----
   // Stimulus
   // ----
   task idle(int n);
      in_valid_i = 0;
      repeat (n) @(negedge clk_i);
   endtask

   task drain();
      in_valid_i = 0;
      while (exp_q.size() != 0)
         @(negedge clk_i);
      idle(3);
   endtask

   task send(int s, int k);
      int sl;
      in_valid_i = 1;
      in_src_i = 4'(s);
      in_kind_i = 2'(k);
      in_data_i = rnd();
      do
         @(posedge clk_i);
      while (in_ready_o !== 1'b1);
      sl = slot_of(s, k);
      if (sl >= 0)
         exp_q.push_back({4'(sl), 2'(k), (k == 2) ? 7'h00 : 7'((sl - 1) * DW), in_data_i});
      @(negedge clk_i);
   endtask

   task power(int r);
      rst_i = 1;
      int_slave_i = (tbl[r][0] != 0);
      switch_i = 4'(tbl[r][1]);
      cnt = 4'(tbl[r][2]);
      gone = 0;
      baud_low_i = r[0];
      auto_m = (tbl[r][3] == 1);
      seen_m = 14'((15'h0001 << cnt) - 15'h0001);
      seen_m = seen_m | (int_slave_i ? 14'((15'h0001 << switch_i) >> 1) : 14'h0000);
      exp_q.delete();
      ovf_m = 0;
      repeat (r == 0 ? 10 : 2) @(negedge clk_i);
      chk("reset", 29'h0004_0000, {in_ready_o, out_valid_o, link_led_o, fault_pulse_o,
         image_ovf_o, lost_o});
      rst_i = 0;
      idle(4);
      if (tbl[r][3] < 2)
         chk("auto", tbl[r][3], link_auto_o);
      chk("err", tbl[r][4], addr_err_o);
      if (r < 4 || r == 6)
         chk("own", tbl[r][1] == 15, own_led_o);
      chk("baud", r[0], baud_low_o);
      switch_i = ~switch_i;
      baud_low_i = !baud_low_i;
      int_slave_i = !int_slave_i;
      idle(3);
      if (tbl[r][3] < 2)
         chk("auto", tbl[r][3], link_auto_o);
      chk("baud", r[0], baud_low_o);
   endtask

   initial
   begin
      for (int r = 0; r < 7; r++)
      begin
         power(r);
         if (r == 0)
         begin
            chk("led", 0, link_led_o);
            for (int k = 0; k < 4; k++)
               for (int s = 0; s < 16; s++)
                  send(s, k);
            drain();
            chk("ovf", ovf_m, image_ovf_o);
            p0 = pulses;
            gone = 1;
            idle(4);
            chk("lost", 14'h0001, lost_o);
            chk("led", 1, link_led_o);
            gone = 0;
            idle(4);
            chk("pulse", 1, pulses - p0);
            chk("lost", 0, {link_led_o, lost_o});
            coil_open_i = 8'(rnd());
            coil_short_i = 8'(rnd());
            idle(2);
            chk("coil", coil_open_i | coil_short_i, coil_fault_o);
         end
         if (r == 1)
         begin
            for (int i = 0; i < 5; i++)
            begin
               {combi_in_cfg_i, combi_out_cfg_i, type_present_i} = (i == 0) ? 7'h7F : 7'(rnd());
               idle(2);
               for (int k = 0; k < 4; k++)
                  for (int s = 0; s < 6; s++)
                     send(s, k);
               drain();
            end
            chk("ovf", ovf_m, image_ovf_o);
            // Two held words must refuse a third until the far side drains.
            hold = 1;
            idle(2);
            send(0, 2);
            send(0, 2);
            chk("full", 0, in_ready_o);
            hold = 0;
            send(0, 2);
            drain();
         end
      end
      conclude();
   end
endmodule
